// ===== inc/acfs_pkg.sv
// constants, field layouts and carrier types for the actuator feedback and status block
// Functional notes
// - report position as 14 bits, 0.1 mm per bit, 0 to 1000.0 mm.
// - report motor current as 9 bits, 0.1 A per bit, up to 51.1 A.
// - report applied duty cycle as 5 bits, 5 percent per step.
// - supply fault code: 00 in range, 01 low, 10 high, 11 unused.
// - supply fault lets running motion finish but refuses new moves.
// - thermal fault code: 00 in range, 01 low, 10 high, 11 unused.
// - thermal fault lets running motion finish but refuses new moves.
// - moving indicator is high exactly while the actuator is in motion.
// - overload set when current exceeds limit continuously for 50 ms.
// - after overload, permit must go low before any new motion starts.
// - back-driven indicator set on uncommanded tube displacement.
// - out-of-range command field sets bad-parameter and inhibits all motion.
// - saturation set while within 10 percent of max speed or current.
// - internal fatal fault sets service-needed and prohibits all motion.
// - the 26 reserved report bits are sent as zero.
// - node identifier is 19 plus the 3-bit address select value.
// - bus at 500 kbit/s, standard 11-bit frames only, extended ignored.
// - control traffic is acted on only in the operational state.
// - id 0 frame, byte 0x01, node byte 0 or own id selects operational.
// - sleep after 120 s of bus silence, wake when activity returns.
// - feedback frame is sent every 100 ms.
// - fields packed LSB first at their fixed byte.bit positions.
// - permit bit low allows no motion but other fields still accepted.
package acfs_pkg;

  // apb register offsets
  localparam logic [7:0] ACFS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ACFS_MOVE_OFS   = 8'h04;
  localparam logic [7:0] ACFS_STAT_OFS   = 8'h08;
  localparam logic [7:0] ACFS_REP_LO_OFS = 8'h0c;
  localparam logic [7:0] ACFS_REP_HI_OFS = 8'h10;

  // command field limits and fault codes
  localparam logic [13:0] ACFS_POS_MAX  = 14'h2710;  // 1000.0 mm
  localparam logic [8:0]  ACFS_CUR_MIN  = 9'h00a;    // 1.0 a
  localparam logic [4:0]  ACFS_SPD_MIN  = 5'h04;     // 20 percent
  localparam logic [4:0]  ACFS_SPD_MAX  = 5'h14;     // 100 percent
  localparam logic [4:0]  ACFS_SAT_DUTY = 5'h12;     // 90 percent
  localparam logic [1:0]  ACFS_ENV_OK   = 2'h0;
  localparam logic [1:0]  ACFS_ENV_LOW  = 2'h1;
  localparam logic [1:0]  ACFS_ENV_HIGH = 2'h2;

  // network management
  localparam logic [7:0]  ACFS_NODE_BASE  = 8'h13;
  localparam logic [10:0] ACFS_NMT_ID     = 11'h000;
  localparam logic [7:0]  ACFS_NMT_START  = 8'h01;
  localparam logic [7:0]  ACFS_NMT_STOP   = 8'h02;
  localparam logic [7:0]  ACFS_NMT_PREOP  = 8'h80;
  localparam logic [7:0]  ACFS_NMT_RST_N  = 8'h81;
  localparam logic [7:0]  ACFS_NMT_RST_C  = 8'h82;
  localparam logic [7:0]  ACFS_NMT_ALL    = 8'h00;
  localparam logic [3:0]  ACFS_NMT_DLC    = 4'h2;
  localparam int          ACFS_BIT_RATE_K = 500;

  // timing
  localparam int ACFS_CLK_KHZ   = 125000;
  localparam int ACFS_TICK_MS   = 1;
  localparam int ACFS_TICK_CYC  = ACFS_CLK_KHZ * ACFS_TICK_MS;
  localparam int ACFS_PERIOD_MS = 100;
  localparam int ACFS_SLEEP_S   = 120;
  localparam int ACFS_SLEEP_MS  = ACFS_SLEEP_S * 1000;
  localparam int ACFS_OVL_MS    = 50;
  localparam int ACFS_OVL_CYC   = ACFS_OVL_MS * ACFS_CLK_KHZ;
  localparam int ACFS_TICK_W    = 17;
  localparam int ACFS_MS_W      = 17;
  localparam int ACFS_PER_W     = 7;
  localparam int ACFS_OVL_W     = 23;

  // reset values
  localparam logic [7:0]  ACFS_CTRL_RST = 8'h00;
  localparam logic [31:0] ACFS_ZERO32   = 32'h0000_0000;

  typedef enum logic [2:0] {
    ACFS_PREOP = 3'b001,
    ACFS_OPER  = 3'b010,
    ACFS_STOPD = 3'b100
  } acfs_nmt_e;

  // feedback frame, bit 0 of byte 1 is bit 0 of the struct
  typedef struct packed {
    logic [25:0] rsvd;
    logic        fatal;
    logic        sat;
    logic        param;
    logic        backdrive;
    logic        ovl;
    logic        moving;
    logic [1:0]  temp;
    logic [1:0]  volt;
    logic [4:0]  duty;
    logic [8:0]  cur;
    logic [13:0] pos;
  } acfs_report_s;

  // control word as software writes it
  typedef struct packed {
    logic        permit;
    logic [4:0]  spd;
    logic [8:0]  cur_lim;
    logic [13:0] pos;
  } acfs_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic        ide;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [15:0] data;
  } acfs_rx_s;

  typedef struct packed {
    logic [13:0] pos;
    logic [8:0]  cur;
    logic [4:0]  duty;
    logic [1:0]  volt;
    logic [1:0]  temp;
    logic        done;
    logic        fatal;
  } acfs_sense_s;

endpackage

// ===== design/acfs_top.sv
// actuator feedback framer, motion gating, node id, nmt and sleep with apb registers
`timescale 1ns/1ps
module acfs_top
  import acfs_pkg::*;
#(
  parameter int          TICK_CYC = ACFS_TICK_CYC,
  parameter int          OVL_CYC  = ACFS_OVL_CYC,
  parameter int          SLEEP_MS = ACFS_SLEEP_MS,
  parameter logic [13:0] BD_TOL   = 14'h0002,
  parameter logic [8:0]  MAX_CUR  = 9'h0fa
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire acfs_rx_s     rx_frame,
  input  wire logic         can_rx_pin,
  input  wire logic [2:0]   addr_sel_pin,
  input  wire acfs_sense_s  sense,
  input  wire logic         tx_ready,
  output logic              tx_valid,
  output acfs_report_s      tx_report,
  output logic              motor_run,
  output logic [7:0]        node_id,
  output logic              sleep_mode
);

  typedef struct packed {
    logic [2:0]             as1;
    logic [2:0]             as2;
    logic [2:0]             as3;
    logic [7:0]             node_id;
    logic                   bs1;
    logic                   bs2;
    logic                   bs3;
    logic                   bq;
    acfs_nmt_e              nmt;
    logic                   sleep;
    logic [ACFS_MS_W-1:0]   idle_ms;
    logic [ACFS_TICK_W-1:0] tick_cnt;
    logic [ACFS_PER_W-1:0]  per_ms;
    acfs_ctrl_s             ctrl;
    logic                   moving;
    logic [ACFS_OVL_W-1:0]  ovl_cnt;
    logic                   ovl_flag;
    logic                   ovl_lock;
    logic [13:0]            bd_pos;
    logic                   bd_flag;
    logic                   param_flag;
    logic                   fatal_flag;
    acfs_report_s           report;
    logic                   tx_valid;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } acfs_state_s;

  acfs_state_s st_r;
  acfs_state_s st_nxt;

  // command field range check
  function automatic logic acfs_bad_cmd(input acfs_ctrl_s c);
    acfs_bad_cmd = (c.pos > ACFS_POS_MAX) || (c.cur_lim < ACFS_CUR_MIN) ||
                   (c.spd < ACFS_SPD_MIN) || (c.spd > ACFS_SPD_MAX);
  endfunction

  // within a tenth of full duty or full current
  function automatic logic acfs_sat(input logic [4:0] d, input logic [8:0] c);
    logic [12:0] lhs;
    logic [12:0] rhs;
    lhs = {4'h0, c} * 13'h00a;
    rhs = {4'h0, MAX_CUR} * 13'h009;
    acfs_sat = (d >= ACFS_SAT_DUTY) || (lhs >= rhs);
  endfunction

  logic apb_wr;
  logic apb_setup;
  logic tick;
  logic send;
  logic activity;
  logic oper;
  logic start_ok;
  logic over_lim;
  logic ovl_trip;
  logic [13:0] bd_diff;
  acfs_ctrl_s  wr_ctrl;

  always_comb begin
    apb_setup = psel && !penable && !st_r.pready;
    apb_wr    = psel && penable && st_r.pready && pwrite;
    wr_ctrl   = acfs_ctrl_s'(pwdata[28:0]);
    oper      = (st_r.nmt == ACFS_OPER);
    tick      = (st_r.tick_cnt == ACFS_TICK_W'(TICK_CYC - 1));
    send      = tick && (st_r.per_ms == ACFS_PER_W'(ACFS_PERIOD_MS - 1));
    activity  = rx_frame.valid || ((st_r.bs2 == st_r.bs3) && (st_r.bs3 != st_r.bq));
    over_lim  = st_r.moving && (sense.cur > st_r.ctrl.cur_lim);
    ovl_trip  = over_lim && (st_r.ovl_cnt == ACFS_OVL_W'(OVL_CYC - 1));
    bd_diff   = (sense.pos > st_r.bd_pos) ? (sense.pos - st_r.bd_pos)
                                          : (st_r.bd_pos - sense.pos);
    start_ok  = oper && st_r.ctrl.permit && !st_r.ovl_lock && !st_r.param_flag &&
                !st_r.fatal_flag && !st_r.sleep && !st_r.moving &&
                (sense.volt == ACFS_ENV_OK) && (sense.temp == ACFS_ENV_OK);
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // address select pins, three stage sampling
    st_nxt.as1 = addr_sel_pin;
    st_nxt.as2 = st_r.as1;
    st_nxt.as3 = st_r.as2;
    if (st_r.as2 == st_r.as3) begin
      st_nxt.node_id = ACFS_NODE_BASE + {5'h00, st_r.as3};
    end
    // bus pin activity sampling
    st_nxt.bs1 = can_rx_pin;
    st_nxt.bs2 = st_r.bs1;
    st_nxt.bs3 = st_r.bs2;
    if (st_r.bs2 == st_r.bs3) begin
      st_nxt.bq = st_r.bs3;
    end

    // millisecond tick and report period
    st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 1'b1;
    if (tick) begin
      st_nxt.per_ms = send ? '0 : st_r.per_ms + 1'b1;
    end

    if (activity) begin
      st_nxt.idle_ms = '0;
      st_nxt.sleep   = 1'b0;
    end else if (tick && !st_r.sleep) begin
      if (st_r.idle_ms == ACFS_MS_W'(SLEEP_MS - 1)) begin
        st_nxt.sleep = 1'b1;
      end else begin
        st_nxt.idle_ms = st_r.idle_ms + 1'b1;
      end
    end

    if (rx_frame.valid && !rx_frame.ide && (rx_frame.id == ACFS_NMT_ID) &&
        (rx_frame.dlc >= ACFS_NMT_DLC) &&
        ((rx_frame.data[15:8] == ACFS_NMT_ALL) || (rx_frame.data[15:8] == st_r.node_id))) begin
      unique case (rx_frame.data[7:0])
        ACFS_NMT_START: st_nxt.nmt = ACFS_OPER;
        ACFS_NMT_STOP:  st_nxt.nmt = ACFS_STOPD;
        ACFS_NMT_PREOP, ACFS_NMT_RST_N, ACFS_NMT_RST_C: st_nxt.nmt = ACFS_PREOP;
        default: st_nxt.nmt = st_r.nmt;
      endcase
    end

    if (apb_wr && oper && (paddr == ACFS_CTRL_OFS)) begin
      // fields taken even with permit low
      st_nxt.ctrl = wr_ctrl;
      st_nxt.param_flag = acfs_bad_cmd(wr_ctrl);
    end

    // lock released once permit seen low
    if (!st_r.ctrl.permit) begin
      st_nxt.ovl_lock = 1'b0;
    end

    st_nxt.ovl_cnt = over_lim ? st_r.ovl_cnt + 1'b1 : '0;

    // motion start and stop
    if (st_r.moving) begin
      // running motion not cut by supply fault
      // running motion not cut by thermal fault
      if (sense.done || ovl_trip || !st_r.ctrl.permit || st_r.param_flag ||
          st_r.fatal_flag || !oper) begin
        st_nxt.moving = 1'b0;
        st_nxt.ovl_cnt = '0;
      end
      st_nxt.bd_pos = sense.pos;
    end else if (apb_wr && (paddr == ACFS_MOVE_OFS) && pwdata[0] && start_ok) begin
      st_nxt.moving   = 1'b1;
      st_nxt.ovl_flag = 1'b0;
      // displacement seen in the start cycle still counts, set wins
      st_nxt.bd_flag  = (bd_diff > BD_TOL);
    end else if (bd_diff > BD_TOL) begin
      st_nxt.bd_flag = 1'b1;
      st_nxt.bd_pos  = sense.pos;
    end
    if (ovl_trip) begin
      st_nxt.ovl_flag = 1'b1;
      st_nxt.ovl_lock = 1'b1;
    end

    if (sense.fatal) begin
      st_nxt.fatal_flag = 1'b1;
    end

    // feedback frame handshake
    if (st_r.tx_valid && tx_ready) begin
      st_nxt.tx_valid = 1'b0;
    end
    if (send && !st_r.sleep) begin
      st_nxt.tx_valid = 1'b1;
      st_nxt.report.pos  = sense.pos;
      st_nxt.report.cur  = sense.cur;
      st_nxt.report.duty = sense.duty;
      st_nxt.report.volt = sense.volt;
      st_nxt.report.temp = sense.temp;
      st_nxt.report.moving    = st_r.moving;
      st_nxt.report.ovl       = st_r.ovl_flag;
      st_nxt.report.backdrive = st_r.bd_flag;
      st_nxt.report.param     = st_r.param_flag;
      st_nxt.report.sat       = st_r.moving && acfs_sat(sense.duty, sense.cur);
      st_nxt.report.fatal     = st_r.fatal_flag;
      st_nxt.report.rsvd      = '0;
    end

    // apb slave, ready in the first access cycle, no wait state
    st_nxt.pready  = apb_setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = ACFS_ZERO32;
    if (apb_setup) begin
      unique case (paddr)
        ACFS_CTRL_OFS:   st_nxt.prdata = {3'h0, st_r.ctrl};
        ACFS_MOVE_OFS:   st_nxt.prdata = {31'h0, st_r.moving};
        ACFS_STAT_OFS:   st_nxt.prdata = {12'h000, st_r.fatal_flag,
                           st_r.report.sat, st_r.param_flag, st_r.bd_flag,
                           st_r.ovl_flag, st_r.ovl_lock, st_r.moving, st_r.sleep,
                           1'b0, st_r.nmt, st_r.node_id};
        ACFS_REP_LO_OFS: st_nxt.prdata = st_r.report[31:0];
        ACFS_REP_HI_OFS: st_nxt.prdata = st_r.report[63:32];
        default:         st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.node_id  <= ACFS_NODE_BASE;
      st_r.nmt      <= ACFS_PREOP;
      st_r.ctrl     <= acfs_ctrl_s'({21'h0, ACFS_CTRL_RST});
      // pin samplers start recessive, so no false edge follows reset
      st_r.bs1      <= 1'b1;
      st_r.bs2      <= 1'b1;
      st_r.bs3      <= 1'b1;
      st_r.bq       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata     = st_r.prdata;
  assign pready     = st_r.pready;
  assign pslverr    = st_r.pslverr;
  assign tx_valid   = st_r.tx_valid;
  assign tx_report  = st_r.report;
  assign motor_run  = st_r.moving;
  assign node_id    = st_r.node_id;
  assign sleep_mode = st_r.sleep;

  default clocking acfs_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // motion gating checks
  volt_gate_a: assert property ($rose(st_r.moving) |-> $past(sense.volt) == ACFS_ENV_OK)
    else $error("motion started with supply fault");
  temp_gate_a: assert property ($rose(st_r.moving) |-> $past(sense.temp) == ACFS_ENV_OK)
    else $error("motion started with thermal fault");
  ovl_lock_a: assert property ($rose(st_r.moving) |-> !$past(st_r.ovl_lock))
    else $error("motion started before permit cleared");
  param_stop_a: assert property (st_r.param_flag && st_r.moving |=> !st_r.moving)
    else $error("motion continued with bad parameter");
  fatal_stop_a: assert property (st_r.fatal_flag |=> !st_r.moving)
    else $error("motion with fatal fault");
  permit_low_a: assert property (st_r.moving && !st_r.ctrl.permit |=> !st_r.moving)
    else $error("motion without permit");
  oper_only_a: assert property ($rose(st_r.moving) |-> $past(st_r.nmt) == ACFS_OPER)
    else $error("motion outside operational state");

  // overload timing
  ovl_set_a: assert property (ovl_trip |=> st_r.ovl_flag && st_r.ovl_lock && !st_r.moving)
    else $error("overload not flagged at limit");
  ovl_early_a: assert property ($rose(st_r.ovl_flag) |-> $past(st_r.ovl_cnt) ==
                                ACFS_OVL_W'(OVL_CYC - 1))
    else $error("overload flagged early");

  // identity, network and sleep
  node_id_a: assert property (st_r.as2 == st_r.as3 |=> st_r.node_id ==
                              ACFS_NODE_BASE + {5'h00, $past(st_r.as3)})
    else $error("node id not base plus select");
  ext_drop_a: assert property (rx_frame.valid && rx_frame.ide |=> st_r.nmt == $past(st_r.nmt))
    else $error("extended frame changed nmt state");
  nmt_start_a: assert property (rx_frame.valid && !rx_frame.ide && rx_frame.id == ACFS_NMT_ID &&
                                rx_frame.dlc >= ACFS_NMT_DLC &&
                                rx_frame.data == 16'h0001 |=> st_r.nmt == ACFS_OPER)
    else $error("broadcast start ignored");
  wake_a: assert property (st_r.sleep && activity |=> !st_r.sleep)
    else $error("no wake on activity");

  // frame contents
  rsvd_zero_a: assert property (st_r.tx_valid |-> st_r.report.rsvd == 26'h0)
    else $error("reserved bits not zero");
  snap_a: assert property (send && !st_r.sleep |=> st_r.tx_valid && st_r.report.moving ==
                           $past(st_r.moving) && st_r.report.pos == $past(sense.pos))
    else $error("report not a snapshot");

  // motion start and stop sources
  done_stop_a: assert property (st_r.moving && sense.done |=> !st_r.moving)
    else $error("motion kept after done");
  oper_lost_a: assert property (st_r.moving && !oper |=> !st_r.moving)
    else $error("motion kept outside operational state");
  move_src_a: assert property ($rose(st_r.moving) |-> $past(apb_wr) &&
      $past(paddr) == ACFS_MOVE_OFS && $past(pwdata[0]))
    else $error("motion started without a move request");
  param_gate_a: assert property ($rose(st_r.moving) |-> !$past(st_r.param_flag))
    else $error("motion started with bad parameter");
  fatal_gate_a: assert property ($rose(st_r.moving) |-> !$past(st_r.fatal_flag))
    else $error("motion started with fatal fault");
  param_set_a: assert property (apb_wr && oper && paddr == ACFS_CTRL_OFS &&
      pwdata[13:0] > ACFS_POS_MAX |=> st_r.param_flag)
    else $error("out of range position not flagged");
  ovl_clear_a: assert property ($rose(st_r.moving) |-> !st_r.ovl_flag)
    else $error("overload flag kept into a new motion");
  bd_set_a: assert property (!st_r.moving && bd_diff > BD_TOL |=> st_r.bd_flag)
    else $error("uncommanded displacement not flagged");

  // report link and sleep
  tx_hold_a: assert property (st_r.tx_valid && !tx_ready && !send |=> st_r.tx_valid)
    else $error("report dropped before it was taken");
  snap_hold_a: assert property (!send |=> $stable(st_r.report))
    else $error("report changed between send instants");
  tx_clear_a: assert property (st_r.tx_valid && tx_ready && !send |=> !st_r.tx_valid)
    else $error("report still offered after it was taken");
  sleep_quiet_a: assert property (st_r.sleep |=> !$rose(st_r.tx_valid))
    else $error("report sent while asleep");
  sleep_set_a: assert property (tick && !activity && !st_r.sleep &&
      st_r.idle_ms == ACFS_MS_W'(SLEEP_MS - 1) |=> st_r.sleep)
    else $error("no sleep after bus silence");
  sat_idle_a: assert property (send && !st_r.sleep && !st_r.moving |=> !st_r.report.sat)
    else $error("saturation reported while idle");

  cover_move_c: cover property ($rose(st_r.moving));
  cover_ovl_c:  cover property ($rose(st_r.ovl_flag));
  cover_tx_c:   cover property (st_r.tx_valid && tx_ready);
  cover_slp_c:  cover property ($rose(st_r.sleep));
  cover_bd_c:   cover property ($rose(st_r.bd_flag));

endmodule // acfs_top

// ===== tb/acfs_host_model.sv
// host can controller model: takes reports and sends nmt frames
`timescale 1ns/1ps
module acfs_host_model
  import acfs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_valid,
  input  wire logic [1:0] lag,
  output logic            tx_ready,
  output acfs_rx_s        rx_frame,
  output logic            can_rx_pin
);
  logic [1:0] wait_r;

  // accepts each report after lag cycles, so both prompt and slow hosts are seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      wait_r   <= 2'h0;
    end else if (tx_valid && !tx_ready && wait_r < lag) begin
      wait_r <= wait_r + 2'h1;
    end else begin
      tx_ready <= tx_valid && !tx_ready;
      wait_r   <= 2'h0;
    end
  end

  // idle bus sits recessive high
  initial begin
    rx_frame   = '0;
    can_rx_pin = 1'b1;
  end

  task automatic send(input logic ext, input logic [10:0] id, input logic [15:0] data);
    @(posedge pclk);
    can_rx_pin <= 1'b0;
    rx_frame   <= '{1'b1, ext, id, 4'h2, data};
    @(posedge pclk);
    can_rx_pin <= 1'b1;
    rx_frame   <= '{1'b0, ~ext, ~id, 4'hd, ~data};
  endtask
endmodule // acfs_host_model

// ===== tb/acfs_top_tb.sv
// self-checking bench for the actuator feedback and status block
`timescale 1ns/1ps
module acfs_top_tb;
  import acfs_pkg::*;
  localparam int TICK = 10;
  localparam int OVL  = 20;
  localparam int SLP  = 1000;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e, b;
  logic         can_rx_pin, tx_ready, tx_valid, motor_run, sleep_mode;
  logic [7:0]   paddr, node_id;
  logic [31:0]  pwdata, prdata, q, seed;
  logic [27:0]  w;
  logic [2:0]   addr_sel;
  logic [1:0]   lag;
  acfs_rx_s     rx_frame;
  acfs_sense_s  sense;
  acfs_report_s tx_report;
  int           error_cnt, n_checks, i, k, c;
  logic [27:0]  cor [5] = '{{5'h04, 9'h00a, 14'h2710}, {5'h14, 9'h1ff, 14'h2711},
                          {5'h0a, 9'h009, 14'h0000}, {5'h03, 9'h050, 14'h0010},
                          {5'h15, 9'h050, 14'h0010}};

  acfs_top #(.TICK_CYC(TICK), .OVL_CYC(OVL), .SLEEP_MS(SLP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .can_rx_pin(can_rx_pin), .addr_sel_pin(addr_sel), .sense(sense),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_report(tx_report), .motor_run(motor_run),
    .node_id(node_id), .sleep_mode(sleep_mode));
  acfs_host_model host (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .lag(lag),
    .tx_ready(tx_ready), .rx_frame(rx_frame), .can_rx_pin(can_rx_pin));

  // 125 mhz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // apb transfer, holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic stat(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, ACFS_STAT_OFS, 32'h0);
    chk(q & m, x);
  endtask

  task automatic ctl(input logic p, input logic [27:0] f);
    apb(1'b1, ACFS_CTRL_OFS, {3'h0, p, f});
  endtask

  task automatic move();
    apb(1'b1, ACFS_MOVE_OFS, 32'h1);
  endtask

  task automatic nmt(input logic x, input logic [15:0] d, input logic [2:0] st);
    host.send(x, 11'h000, d);
    tk(3);
    stat(32'h700, {21'h0, st, 8'h0});
  endtask

  // bounded wait for a report valid level, counting edges in c
  task automatic vwait(input logic lvl);
    int n;
    n = 0;
    while (tx_valid !== lvl && n < 1200) begin
      @(posedge pclk);
      n++;
      c++;
    end
    if (tx_valid !== lvl) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic bad(input logic [27:0] f);
    return f[13:0] > 14'h2710 || f[22:14] < 9'h00a || f[27:23] < 5'h04 || f[27:23] > 5'h14;
  endfunction

  // expected report while moving with no flags pending
  function automatic acfs_report_s er(input acfs_sense_s s);
    acfs_report_s r;
    r        = '0;
    r.pos    = s.pos;
    r.cur    = s.cur;
    r.duty   = s.duty;
    r.volt   = s.volt;
    r.temp   = s.temp;
    r.moving = 1'b1;
    r.sat    = (s.duty >= 5'h12) || (s.cur >= 9'h0e1);
    return r;
  endfunction

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {addr_sel, lag, sense} = '0;
    seed = 32'h0001_2f9e;
    error_cnt = 0;
    n_checks = 0;
    tk(5);
    presetn <= 1'b1;
    // node id over every select value, pre-operational after reset
    for (k = 0; k < 8; k++) begin
      addr_sel <= k[2:0];
      tk(6);
      chk(node_id, 8'h13 + k[7:0]);
      stat(32'h7ff, {21'h0, 3'b001, 8'h13 + k[7:0]});
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1);
    ctl(1'b1, {5'h0a, 9'h1ff, 14'h0100});
    move();
    stat(32'h2000, 32'h0);
    // nmt frames: extended, other node, own stop, broadcast start
    nmt(1'b1, 16'h1a01, 3'b001);
    nmt(1'b0, 16'h1501, 3'b001);
    nmt(1'b0, 16'h1a02, 3'b100);
    nmt(1'b0, 16'h0001, 3'b010);
    // corner then random control fields
    for (k = 0; k < 12; k++) begin
      seed = nxt(seed);
      w = (k < 5) ? cor[k] : seed[27:0];
      b = bad(w);
      ctl(1'b1, w);
      stat(32'h20000, {14'h0, b, 17'h0});
      if (b) move();
      if (b) stat(32'h2000, 32'h0);
    end
    ctl(1'b0, {5'h0a, 9'h1ff, 14'h0100});
    move();
    stat(32'h22000, 32'h0);
    ctl(1'b1, {5'h0a, 9'h1ff, 14'h0100});
    sense.volt <= 2'h1;
    move();
    stat(32'h2000, 32'h0);
    sense.volt <= 2'h0;
    sense.temp <= 2'h2;
    move();
    stat(32'h2000, 32'h0);
    sense.temp <= 2'h0;
    move();
    tk(1);
    chk(motor_run, 1'b1);
    sense.volt <= 2'h2;
    sense.temp <= 2'h1;
    tk(5);
    chk(motor_run, 1'b1);
    // periodic reports during motion with random sense values
    host.send(1'b0, 11'h000, 16'h1a01);
    for (i = 0; i < 4; i++) begin
      vwait(1'b0);
      vwait(1'b1);
      if (i > 0) chk(c, 1000);
      c = 0;
      chk(tx_report, er(sense));
      seed = nxt(seed);
      sense.pos  <= {1'b0, seed[12:0]};
      sense.cur  <= seed[22:14];
      sense.duty <= 5'(seed[27:23] % 5'd21);
      sense.volt <= 2'(seed[29:28] % 2'd3);
      sense.temp <= 2'(seed[31:30] % 2'd3);
      lag        <= seed[3:2];
    end
    sense.done <= 1'b1;
    tk(1);
    sense.done <= 1'b0;
    tk(2);
    chk(motor_run, 1'b0);
    // overload: broken run is not counted, a full run trips
    {sense.volt, sense.temp} <= 4'h0;
    sense.cur <= 9'h040;
    ctl(1'b1, {5'h0a, 9'h050, 14'h0100});
    move();
    sense.cur <= 9'h051;
    tk(OVL - 2);
    sense.cur <= 9'h040;
    tk(2);
    chk(motor_run, 1'b1);
    sense.cur <= 9'h051;
    tk(OVL + 4);
    stat(32'he000, 32'hc000);
    move();
    stat(32'h2000, 32'h0);
    sense.cur <= 9'h040;
    ctl(1'b0, {5'h0a, 9'h050, 14'h0100});
    ctl(1'b1, {5'h0a, 9'h050, 14'h0100});
    move();
    stat(32'ha000, 32'h2000);
    sense.pos  <= 14'h0200;
    sense.done <= 1'b1;
    tk(1);
    sense.done <= 1'b0;
    tk(3);
    // uncommanded displacement at and beyond tolerance
    sense.pos <= 14'h0202;
    tk(4);
    stat(32'h10000, 32'h0);
    sense.pos <= 14'h0203;
    tk(4);
    stat(32'h10000, 32'h10000);
    sense.fatal <= 1'b1;
    tk(1);
    sense.fatal <= 1'b0;
    tk(2);
    stat(32'h80000, 32'h80000);
    move();
    stat(32'h2000, 32'h0);
    // sleep after bus silence, no reports, wake on a frame
    host.send(1'b0, 11'h000, 16'h1a01);
    c = 0;
    while (sleep_mode !== 1'b1 && c < 12000) begin
      @(posedge pclk);
      c++;
    end
    chk(c >= 9980 && c <= 10030, 1'b1);
    // a report launched on the sleep-entry tick is still being taken
    tk(8);
    c = 0;
    repeat (1100) begin
      @(posedge pclk);
      if (tx_valid === 1'b1) c++;
    end
    chk(c, 0);
    host.send(1'b0, 11'h000, 16'h1a01);
    tk(6);
    chk(sleep_mode, 1'b0);
    report_and_stop();
  end
endmodule // acfs_top_tb
